// ---- src/serial_eeprom_ctrl.sv ----
// Command decoder and control logic of a three-wire serial EEPROM.
// ******************************************************
// Overview of operation
// RL1: Start bit is first rising clock with select and input both high.
// RL2: Nothing happens before start; raising select only leaves standby.
// RL3: Execute only after all opcode, address and data bits arrive.
// RL4: After the last bit, ignore clock and input until new start.
// RL5: Opcode 10 read, 01 write, 11 erase, 00 uses two address bits.
// RL6: Nine address bits MSB first; long frames 20 clocks, short 12.
// RL7: Word width select high gives 16-bit words, low gives 8-bit.
// RL8: Input bits are sampled on each rising serial clock edge.
// RL9: Output is high impedance except read data or busy status.
// RL10: Status drives low while programming, high when ready.
// RL11: Output goes high impedance on every select falling edge.
// RL12: Power up with programming disabled; enable needed first.
// RL13: Enable holds until disable; reads work in either state.
// RL14: Host should disable programming after each program operation.
// RL15: Read sends a zero bit then the word, changing on rising clock.
// RL16: Held select advances address and continues reading.
// RL17: Erase sets word to ones, started by select falling after address.
// RL18: Host drops select before next clock after last data bit.
// RL19: Busy shows only if select rises after 250 ns low during cycle.
// RL20: Word erase or write takes 4 ms; erase-all takes 8 ms.
// RL21: Write-all erases then writes all words in 16 ms, needs enable.
// RL22: Programming runs without serial clock edges.
// RL23: A started cycle finishes even with select low.
// RL24: Select low at least 250 ns; low select resets command logic.
// RL25: No status when select stays low or high through the cycle.
// RL26: Disabled programming commands are discarded, no busy period.
// ******************************************************
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_ctrl #(
    parameter logic [23:0] WORD_TIME = 24'(serial_eeprom_pkg::WORD_CYCLES),
    parameter logic [23:0] ERASE_ALL_TIME = 24'(serial_eeprom_pkg::ERASE_ALL_CYCLES),
    parameter logic [23:0] WRITE_ALL_TIME = 24'(serial_eeprom_pkg::WRITE_ALL_CYCLES)
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire serial_eeprom_pkg::serial_pins_s pins,
    input wire logic word_width_select,
    output logic serial_out,
    output logic serial_out_en,
    output logic busy,
    output logic program_enabled
);
    localparam int AW = serial_eeprom_pkg::ADDR_BITS;

    typedef struct packed {
        serial_eeprom_pkg::cmd_state_e st;
        logic cs;
        logic sck;
        logic [4:0] cnt;
        logic [1:0] op;
        logic [AW-1:0] addr;
        logic [15:0] sh;
        logic wide;
        logic en;
        serial_eeprom_pkg::prog_kind_e pk;
        logic all;
        logic [1:0] step;
        logic [7:0] low_cnt;
        logic show;
        logic so;
        logic so_en;
        logic busy;
        logic fetch;
        logic half;
    } ctrl_s;

    ctrl_s q, d;
    logic [7:0] rd_byte;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic tmr_load;
    logic [23:0] tmr_count;
    logic tmr_run;
    logic tmr_done;
    logic rise;
    logic cs_fall;
    logic cs_rise;

    // Frame length depends on opcode and extended sub-code, so it lives in a function.
    function automatic logic [4:0] frame_len(input logic [1:0] op, input logic [1:0] sub);
        if (op == serial_eeprom_pkg::OP_READ || op == serial_eeprom_pkg::OP_WRITE) begin
            frame_len = serial_eeprom_pkg::FRAME_LONG;
        end else if (op == serial_eeprom_pkg::OP_EXT && sub == serial_eeprom_pkg::SUB_WRITE_ALL) begin
            frame_len = serial_eeprom_pkg::FRAME_LONG;
        end else begin
            frame_len = serial_eeprom_pkg::FRAME_SHORT;
        end
    endfunction : frame_len

    // ******************************************************
    // Array and programming timer
    // ******************************************************
    eeprom_array u_array (
        .clk(clk),
        .wr_en(mem_we),
        .fill_all(q.all),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(d.addr),
        .rd_data(rd_byte)
    );

    program_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(tmr_load),
        .count(tmr_count),
        .running(tmr_run),
        .done(tmr_done)
    );

    assign rise = pins.serial_clk && !q.sck; // RL8
    assign cs_fall = q.cs && !pins.chip_select;
    assign cs_rise = !q.cs && pins.chip_select;

    // ******************************************************
    // Control
    // ******************************************************
    always_comb begin
        logic [4:0] n;
        logic [1:0] sub;
        n = q.cnt + 5'h01;
        // The leading address bits sit one place lower until the last address bit lands.
        sub = (q.cnt <= serial_eeprom_pkg::HDR_BITS) ? q.addr[AW-2 -: 2] : q.addr[AW-1 -: 2];
        d = q;
        d.cs = pins.chip_select;
        d.sck = pins.serial_clk;
        d.fetch = 1'b0;
        mem_we = 1'b0;
        mem_waddr = q.addr;
        mem_wdata = 8'hff;
        tmr_load = 1'b0;
        tmr_count = WORD_TIME;

        // Programming runs on the core clock alone, whatever select does.
        if (tmr_done) begin // RL22 RL23
            d.busy = 1'b0;
        end
        // Write and write-all store the data, erase stores ones; each byte of a single wide word is a separate write.
        if (q.busy && tmr_run && q.half) begin
            mem_we = 1'b1;
            mem_wdata = (q.pk == serial_eeprom_pkg::PG_WRITE) ? q.sh[7:0] : 8'hff; // RL17 RL21
            if (q.wide) begin
                mem_waddr = {q.addr[AW-2:0], q.step[0]};
                mem_wdata = q.step[0] ? q.sh[7:0] : q.sh[15:8];
                if (q.pk == serial_eeprom_pkg::PG_ERASE) begin
                    mem_wdata = 8'hff;
                end
            end
            d.step = q.step + 2'h1;
            if (q.step[0] || !q.wide || q.all) begin
                d.half = 1'b0;
            end
        end

        if (!pins.chip_select) begin // RL24
            if (cs_fall && q.st == serial_eeprom_pkg::ST_ARMED && q.en
                    && (!q.busy || tmr_done)) begin // RL17 RL18
                d.busy = 1'b1;
                d.half = 1'b1;
                d.step = 2'h0;
                tmr_load = 1'b1;
                if (q.all) begin
                    tmr_count = (q.pk == serial_eeprom_pkg::PG_WRITE) ? WRITE_ALL_TIME
                                                                     : ERASE_ALL_TIME; // RL20 RL21
                end
            end
            d.st = serial_eeprom_pkg::ST_IDLE;
            d.cnt = 5'h00;
            d.so_en = 1'b0; // RL11
            d.show = 1'b0;
            if (q.low_cnt < 8'(serial_eeprom_pkg::CS_LOW_CYCLES)) begin
                d.low_cnt = q.low_cnt + 8'h01;
            end
        end else begin
            d.low_cnt = 8'h00;
            // Status only after a low of the full minimum time during a cycle.
            if (cs_rise && q.busy && q.low_cnt >= 8'(serial_eeprom_pkg::CS_LOW_CYCLES)) begin // RL19 RL25
                d.show = 1'b1;
            end
            if (q.show && q.st == serial_eeprom_pkg::ST_IDLE) begin
                d.so_en = 1'b1; // RL9
                d.so = !q.busy; // RL10
            end
            case (q.st)
                serial_eeprom_pkg::ST_IDLE: begin
                    if (rise && pins.serial_in) begin // RL1 RL2
                        d.st = serial_eeprom_pkg::ST_SHIFT;
                        d.cnt = 5'h01;
                        d.wide = word_width_select; // RL7
                        d.so_en = 1'b0;
                        d.show = 1'b0;
                    end
                end
                serial_eeprom_pkg::ST_SHIFT: begin
                    if (rise) begin
                        d.cnt = n;
                        if (q.cnt <= 5'(serial_eeprom_pkg::OP_BITS)) begin
                            d.op = {q.op[0], pins.serial_in}; // RL5
                        end else if (q.cnt <= serial_eeprom_pkg::HDR_BITS) begin
                            d.addr = {q.addr[AW-2:0], pins.serial_in}; // RL6
                        end else begin
                            d.sh = {q.sh[14:0], pins.serial_in};
                        end
                        if (n == frame_len(q.op, sub) || (q.op == serial_eeprom_pkg::OP_READ
                                && n == serial_eeprom_pkg::HDR_BITS + 5'h01)) begin // RL3 RL6
                            d.st = serial_eeprom_pkg::ST_DONE; // RL4
                            d.all = 1'b0;
                            d.pk = serial_eeprom_pkg::PG_OFF;
                            case (q.op)
                                serial_eeprom_pkg::OP_READ: begin
                                    d.st = serial_eeprom_pkg::ST_READ; // RL13
                                    d.so_en = 1'b1;
                                    d.so = 1'b0; // RL15
                                    d.cnt = 5'h00;
                                    d.fetch = 1'b1;
                                    d.addr = q.wide ? {d.addr[AW-2:0], 1'b0} : d.addr; // RL7
                                end
                                serial_eeprom_pkg::OP_WRITE: begin
                                    d.st = serial_eeprom_pkg::ST_ARMED;
                                    d.pk = serial_eeprom_pkg::PG_WRITE;
                                end
                                serial_eeprom_pkg::OP_ERASE: begin
                                    d.st = serial_eeprom_pkg::ST_ARMED;
                                    d.pk = serial_eeprom_pkg::PG_ERASE;
                                end
                                default: begin
                                    case (sub)
                                        serial_eeprom_pkg::SUB_ENABLE: d.en = 1'b1; // RL12 RL13
                                        serial_eeprom_pkg::SUB_DISABLE: d.en = 1'b0; // RL13
                                        serial_eeprom_pkg::SUB_ERASE_ALL: begin
                                            d.st = serial_eeprom_pkg::ST_ARMED;
                                            d.pk = serial_eeprom_pkg::PG_ERASE;
                                            d.all = 1'b1;
                                        end
                                        default: begin
                                            d.st = serial_eeprom_pkg::ST_ARMED;
                                            d.pk = serial_eeprom_pkg::PG_WRITE;
                                            d.all = 1'b1;
                                        end
                                    endcase
                                end
                            endcase
                            // A disabled device keeps a write or erase frame but never arms it.
                            if (!q.en && q.op != serial_eeprom_pkg::OP_READ
                                    && q.op != serial_eeprom_pkg::OP_EXT) begin // RL26
                                d.st = serial_eeprom_pkg::ST_DONE;
                            end
                        end
                    end
                end
                serial_eeprom_pkg::ST_READ: begin
                    // Read data for the current address lands one cycle after fetch.
                    if (q.fetch) begin
                        d.sh = q.wide ? {rd_byte, 8'h00} : {rd_byte, 8'h00};
                        d.addr = {q.addr[AW-1:1], q.addr[0] | q.wide};
                    end
                    if (rise) begin // RL15
                        d.cnt = n;
                        d.so = q.sh[15];
                        d.sh = {q.sh[14:0], 1'b0};
                        if (q.wide && q.cnt == 5'h07) begin
                            d.sh = {rd_byte, 8'h00};
                        end
                        if (n == (q.wide ? 5'h10 : 5'h08)) begin // RL16
                            d.cnt = 5'h00;
                            d.addr = q.addr + AW'(1);
                            d.fetch = 1'b1;
                        end
                    end
                end
                default: begin
                    d.st = q.st; // RL4
                end
            endcase
        end
        // Write-all needs the low byte to repeat in byte mode.
        if (q.st != serial_eeprom_pkg::ST_SHIFT && q.st != serial_eeprom_pkg::ST_READ
                && !q.wide && q.busy) begin
            d.sh = q.sh;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{st: serial_eeprom_pkg::ST_IDLE, pk: serial_eeprom_pkg::PG_OFF, default: '0};
        end else begin
            q <= d;
        end
    end

    assign serial_out = q.so;
    assign serial_out_en = q.so_en;
    assign busy = q.busy;
    assign program_enabled = q.en;
endmodule : serial_eeprom_ctrl
`default_nettype wire

// ---- include/serial_eeprom_pkg.sv ----
// Package with constants, enums and carrier structs of the serial EEPROM command interface.
package serial_eeprom_pkg;

    // ******************************************************
    // Organisation and frame geometry
    // ******************************************************
    localparam int ADDR_BITS = 9;
    localparam int WORD_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int DEPTH_BYTES = 512;
    localparam int OP_BITS = 2;
    localparam logic [4:0] FRAME_LONG = 5'h14;
    localparam logic [4:0] FRAME_SHORT = 5'h0c;
    localparam logic [4:0] HDR_BITS = 5'h0b;

    // ******************************************************
    // Opcodes and extended sub-codes
    // ******************************************************
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_ENABLE = 2'h3;

    // ******************************************************
    // Timing
    // ******************************************************
    localparam longint CLK_HZ = 250000000;
    localparam longint WORD_CYCLE_MS = 4;
    localparam longint ERASE_ALL_MS = 8;
    localparam longint WRITE_ALL_MS = 16;
    localparam int CS_LOW_NS = 250;
    localparam int CLK_PERIOD_NS = 4;
    localparam longint WORD_CYCLES = WORD_CYCLE_MS * CLK_HZ / 1000;
    localparam longint ERASE_ALL_CYCLES = ERASE_ALL_MS * CLK_HZ / 1000;
    localparam longint WRITE_ALL_CYCLES = WRITE_ALL_MS * CLK_HZ / 1000;
    localparam int CS_LOW_CYCLES = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_BITS = 24;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SHIFT = 5'h02,
        ST_READ = 5'h04,
        ST_DONE = 5'h08,
        ST_ARMED = 5'h10
    } cmd_state_e;

    typedef enum logic [2:0] {
        PG_OFF = 3'h1,
        PG_ERASE = 3'h2,
        PG_WRITE = 3'h4
    } prog_kind_e;

    typedef struct packed {
        logic chip_select;
        logic serial_clk;
        logic serial_in;
    } serial_pins_s;

    typedef struct packed {
        logic wr_en;
        logic all;
        logic [ADDR_BITS-1:0] addr;
        logic [WORD_BITS-1:0] data;
        logic wide;
    } mem_req_s;

endpackage : serial_eeprom_pkg

// ---- src/eeprom_array.sv ----
// Byte array with registered read data and a whole-array fill.
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
    parameter int DEPTH = serial_eeprom_pkg::DEPTH_BYTES,
    parameter int AW = serial_eeprom_pkg::ADDR_BITS
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic fill_all,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    // The array holds no reset: stored data must survive a logic reset.
    always_ff @(posedge clk) begin
        if (wr_en && fill_all) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= wr_data;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : eeprom_array
`default_nettype wire

// ---- src/program_timer.sv ----
// Down counter that times a self-timed programming cycle.
`timescale 1ns/1ps
`default_nettype none
module program_timer #(
    parameter int W = serial_eeprom_pkg::TIMER_BITS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic running,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic fin;
    } tmr_s;
    tmr_s q, d;

    always_comb begin
        d = q;
        d.fin = 1'b0;
        if (load) begin
            d.cnt = count;
            d.run = 1'b1;
        end else if (q.run) begin
            if (q.cnt <= 1) begin
                d.run = 1'b0;
                d.fin = 1'b1;
            end
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign running = q.run;
    assign done = q.fin;
endmodule : program_timer
`default_nettype wire

// ---- verification/serial_host.sv ----
// Behavioural host controller that drives the three-wire command bus.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input wire logic clk,
    output var serial_eeprom_pkg::serial_pins_s pins,
    input wire logic serial_out
);
    // ******************************************************
    // Bus primitives, all launched on the falling core clock
    // ******************************************************
    initial begin
        pins = '0;
    end

    task automatic pulse(input logic b);
        @(negedge clk);
        pins.serial_in = b;
        repeat (3) @(negedge clk);
        pins.serial_clk = 1'b1;
        repeat (4) @(negedge clk);
        pins.serial_clk = 1'b0;
    endtask : pulse

    task automatic frame(input logic [23:0] bits, input int n);
        @(negedge clk);
        pins.chip_select = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            pulse(bits[i]);
        end
    endtask : frame

    // Data line is don't-care while reading, so it toggles to expose stale sampling.
    task automatic shift_out(input int n, output logic [16:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            repeat (3) @(negedge clk);
            v = {v[15:0], serial_out};
            pins.serial_in = ~pins.serial_in;
            pins.serial_clk = 1'b1;
            repeat (4) @(negedge clk);
            pins.serial_clk = 1'b0;
        end
    endtask : shift_out

    task automatic release_bus();
        @(negedge clk);
        pins.chip_select = 1'b0;
        pins.serial_in = ~pins.serial_in;
        repeat (70) @(negedge clk);
    endtask : release_bus

    task automatic poll();
        @(negedge clk);
        pins.chip_select = 1'b1;
    endtask : poll
endmodule : serial_host
`default_nettype wire

// ---- verification/serial_eeprom_ctrl_asserts.sv ----
// Concurrent checks on the ports of the serial EEPROM command interface.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_ctrl_asserts #(
    parameter logic [23:0] WORD_TIME = 24'h00012c,
    parameter logic [23:0] ERASE_ALL_TIME = 24'h000258,
    parameter logic [23:0] WRITE_ALL_TIME = 24'h0004b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire serial_eeprom_pkg::serial_pins_s pins,
    input wire logic word_width_select,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic busy,
    input wire logic program_enabled
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Length of the current busy period, so its figure can be checked on exit.
    logic [23:0] run_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= '0;
        end else begin
            run_q <= busy ? run_q + 24'h1 : 24'h0;
        end
    end

    property p_deselect_float;
        !pins.chip_select |-> ##[1:2] !serial_out_en;
    endproperty
    a_deselect_float: assert property (p_deselect_float) else $error("output still driven");
    property p_power_up;
        $rose(reset_n) |-> !program_enabled && !busy;
    endproperty
    a_power_up: assert property (p_power_up) else $error("enabled after reset");
    property p_status_busy;
        serial_out_en && busy && $past(busy) |-> !serial_out;
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("busy not shown low");
    property p_status_ready;
        serial_out_en && $fell(busy) |-> ##[0:1] serial_out;
    endproperty
    a_status_ready: assert property (p_status_ready) else $error("ready not shown high");
    property p_quiet_start;
        $rose(busy) |-> !serial_out_en;
    endproperty
    a_quiet_start: assert property (p_quiet_start) else $error("status without poll");
    property p_cycle_time;
        $fell(busy) |-> run_q inside {[WORD_TIME - 24'h1 : WORD_TIME + 24'h1],
            [ERASE_ALL_TIME - 24'h1 : ERASE_ALL_TIME + 24'h1],
            [WRITE_ALL_TIME - 24'h1 : WRITE_ALL_TIME + 24'h1]};
    endproperty
    a_cycle_time: assert property (p_cycle_time) else $error("cycle length wrong");
    property p_self_timed;
        $rose(busy) |=> busy [*8];
    endproperty
    a_self_timed: assert property (p_self_timed) else $error("cycle cut short");
    property p_needs_enable;
        $rose(busy) |-> program_enabled;
    endproperty
    a_needs_enable: assert property (p_needs_enable) else $error("program while off");
    property p_drive_selected;
        $rose(serial_out_en) |-> $past(pins.chip_select);
    endproperty
    a_drive_selected: assert property (p_drive_selected) else $error("drive unselected");
    property p_dummy_zero;
        $rose(serial_out_en) && !busy |-> !serial_out;
    endproperty
    a_dummy_zero: assert property (p_dummy_zero) else $error("no leading zero");
endmodule : serial_eeprom_ctrl_asserts

bind serial_eeprom_ctrl serial_eeprom_ctrl_asserts #(
    .WORD_TIME(WORD_TIME),
    .ERASE_ALL_TIME(ERASE_ALL_TIME),
    .WRITE_ALL_TIME(WRITE_ALL_TIME)
) serial_eeprom_ctrl_asserts_inst (.clk(clk), .reset_n(reset_n), .pins(pins),
    .word_width_select(word_width_select), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .busy(busy), .program_enabled(program_enabled));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking testbench of the serial EEPROM command interface.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Shortened cycle times keep the run small; checks scale with them.
    localparam int WT = 300;
    localparam int EA = 600;
    localparam int WA = 1200;
    logic clk;
    logic reset_n;
    logic word_width_select;
    wire serial_eeprom_pkg::serial_pins_s pins;
    wire logic serial_out;
    wire logic serial_out_en;
    wire logic busy;
    wire logic program_enabled;
    int mismatches;
    int n_tests;

    serial_eeprom_ctrl #(.WORD_TIME(24'(WT)), .ERASE_ALL_TIME(24'(EA)), .WRITE_ALL_TIME(24'(WA)))
    serial_eeprom_ctrl_inst (.clk(clk), .reset_n(reset_n), .pins(pins),
        .word_width_select(word_width_select), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .busy(busy), .program_enabled(program_enabled));
    serial_host serial_host_inst (.clk(clk), .pins(pins), .serial_out(serial_out));

    always #2 clk = ~clk;

    // ******************************************************
    // Helpers
    // ******************************************************
    function automatic logic [11:0] cmd(input logic [1:0] op, input logic [8:0] a);
        return {1'b1, op, a};
    endfunction : cmd

    task automatic complete_run();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_idle(output int cyc);
        cyc = 0;
        while (busy !== 1'b0 && cyc < 5000) begin
            @(negedge clk);
            cyc++;
        end
        if (cyc >= 5000) begin
            mismatches++;
            complete_run();
        end
    endtask : wait_idle

    // A t of zero means the frame must be absorbed with no busy period.
    task automatic prog(input logic [23:0] bits, input int n, input int t, input logic show);
        int cyc;
        int el;
        serial_host_inst.frame(bits, n);
        serial_host_inst.release_bus();
        if (show) begin
            serial_host_inst.poll();
            repeat (4) @(negedge clk);
            chk(17'(serial_out_en), 17'h1);
            chk(17'(serial_out), 17'h0);
        end else begin
            chk(17'(serial_out_en), 17'h0);
        end
        wait_idle(cyc);
        el = cyc + (show ? 75 : 70);
        chk(17'((t == 0) ? (cyc == 0) : (el >= t && el <= t + 4)), 17'h1);
        if (show) begin
            repeat (4) @(negedge clk);
            chk(17'(serial_out), 17'h1);
            serial_host_inst.release_bus();
        end
    endtask : prog

    task automatic rd(input logic [8:0] a, input int n, input logic [16:0] exp);
        logic [16:0] v;
        serial_host_inst.frame({12'h0, cmd(serial_eeprom_pkg::OP_READ, a)}, 12);
        serial_host_inst.shift_out(n, v);
        chk(v, exp);
        serial_host_inst.release_bus();
    endtask : rd

    // ******************************************************
    // Main sequence
    // ******************************************************
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        word_width_select = 1'b0;
        mismatches = 0;
        n_tests = 0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(17'(program_enabled), 17'h0);
        prog({4'h0, cmd(serial_eeprom_pkg::OP_WRITE, 9'h005), 8'h11}, 20, 0, 1'b0);
        serial_host_inst.frame({9'h0, 3'h0, cmd(2'h0, {2'h3, 7'h0})}, 15);
        serial_host_inst.frame({12'h0, cmd(serial_eeprom_pkg::OP_ERASE, 9'h005)}, 12);
        serial_host_inst.release_bus();
        chk(17'(busy), 17'h0);
        chk(17'(program_enabled), 17'h1);
        prog({4'h0, cmd(2'h0, {2'h1, 7'h0}), 8'h3c}, 20, WA, 1'b1);
        prog({4'h0, cmd(serial_eeprom_pkg::OP_WRITE, 9'h1ff), 8'ha5}, 20, WT, 1'b0);
        prog({4'h0, cmd(serial_eeprom_pkg::OP_WRITE, 9'h000), 8'h5a}, 20, WT, 1'b1);
        prog({12'h0, cmd(serial_eeprom_pkg::OP_ERASE, 9'h100)}, 12, WT, 1'b1);
        rd(9'h0ff, 17, {1'b0, 8'h3c, 8'hff});
        rd(9'h1ff, 9, {8'h0, 1'b0, 8'ha5});
        rd(9'h000, 9, {8'h0, 1'b0, 8'h5a});
        prog({12'h0, cmd(2'h0, {2'h2, 7'h0})}, 12, EA, 1'b1);
        rd(9'h1ff, 9, {8'h0, 1'b0, 8'hff});
        prog({12'h0, cmd(2'h0, 9'h000)}, 12, 0, 1'b0);
        chk(17'(program_enabled), 17'h0);
        rd(9'h005, 9, {8'h0, 1'b0, 8'hff});
        word_width_select = 1'b1;
        rd(9'h000, 17, {1'b0, 16'hffff});
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
